// File: core/smc_pkg.sv
// package: sleep modes, domain enable layout and wake timing for the sleep controller
package smc_pkg;

  // selectable sleep modes, three-bit select field
  typedef enum logic [2:0] {
    SMC_MODE_IDLE     = 3'h0,
    SMC_MODE_ADC_NR   = 3'h1,
    SMC_MODE_PWR_DOWN = 3'h2,
    SMC_MODE_PWR_SAVE = 3'h3,
    SMC_MODE_RSVD4    = 3'h4,
    SMC_MODE_RSVD5    = 3'h5,
    SMC_MODE_STANDBY  = 3'h6,
    SMC_MODE_EXT_STBY = 3'h7
  } smc_mode_t;

  // one enable per clock domain or functional unit
  typedef struct packed {
    logic cpu;
    logic mem;
    logic timer;
    logic spi;
    logic irq;
    logic async_tmr;
    logic adc;
    logic osc;
  } smc_dom_t;

  localparam int SMC_DOM_W = 8;
  localparam smc_dom_t SMC_DOM_ALL = 8'hff;
  localparam smc_dom_t SMC_DOM_NONE = 8'h00;

  // wake restart delay: oscillator settle time in ns, and cycles at 125 MHz
  localparam int SMC_CLK_PERIOD_NS = 8;
  localparam int SMC_WAKE_SETTLE_NS = 64;
  localparam int SMC_WAKE_CYC =
    (SMC_WAKE_SETTLE_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;
  localparam int SMC_CNT_W = 16;
  localparam logic [SMC_CNT_W-1:0] SMC_CNT_ONE = 16'h0001;
  localparam logic [SMC_CNT_W-1:0] SMC_CNT_ZERO = 16'h0000;

endpackage

// File: core/smc_sync.sv
// two-flop synchroniser for asynchronous wake inputs
`timescale 1ns/100ps
`default_nettype none
module smc_sync #(
  parameter int W = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // smc_sync
`default_nettype wire

// File: core/smc_sleep_ctrl.sv
// sleep mode controller: per-mode domain gating and wake sequencing
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl #(
  parameter int WAKE_CYC = smc_pkg::SMC_WAKE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] mode_sel_i,
  input wire logic mode_wr_i,
  input wire logic sleep_en_i,
  input wire logic sleep_req_i,
  input wire logic irq_pend_i,
  input wire logic ext_irq_i,
  input wire logic async_irq_i,
  output var smc_pkg::smc_dom_t dom_en_o,
  output logic cpu_run_o,
  output logic asleep_o,
  output logic [2:0] mode_o,
  output logic mode_bad_o
);

  // ***************************************************************
  // input synchronisation
  // ***************************************************************
  logic [1:0] pin_sync;
  logic ext_irq_s;
  logic async_irq_s;

  // external and async-timer wakes come from other domains
  smc_sync #(.W(2)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({ext_irq_i, async_irq_i}),
    .sync_o(pin_sync)
  );
  assign ext_irq_s = pin_sync[1];
  assign async_irq_s = pin_sync[0];

  // ***************************************************************
  // mode selection field
  // ***************************************************************
  smc_pkg::smc_mode_t mode_ff;
  logic bad_ff;
  logic mode_legal;
  smc_pkg::smc_mode_t nxt_mode;

  // field value after this edge, so gating never lags the reported mode
  assign nxt_mode = (mode_wr_i && mode_legal) ?
    smc_pkg::smc_mode_t'(mode_sel_i) : mode_ff;

  // the two reserved codes are refused and flagged
  always_comb begin
    mode_legal = 1'b1;
    if (mode_sel_i == smc_pkg::SMC_MODE_RSVD4) begin
      mode_legal = 1'b0;
    end else if (mode_sel_i == smc_pkg::SMC_MODE_RSVD5) begin
      mode_legal = 1'b0;
    end
  end

  // software-written select, held until the next legal write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_ff <= smc_pkg::SMC_MODE_IDLE;
      bad_ff <= 1'b0;
    end else if (mode_wr_i) begin
      bad_ff <= !mode_legal;
      if (mode_legal) begin
        mode_ff <= smc_pkg::smc_mode_t'(mode_sel_i);
      end
    end
  end

  // ***************************************************************
  // per-mode domain map
  // ***************************************************************
  smc_pkg::smc_dom_t sleep_map;

  always_comb begin
    sleep_map = smc_pkg::SMC_DOM_NONE;
    case (nxt_mode)
      smc_pkg::SMC_MODE_IDLE: begin
        sleep_map = smc_pkg::SMC_DOM_ALL;
        sleep_map.cpu = 1'b0;
        sleep_map.adc = 1'b0;
      end
      smc_pkg::SMC_MODE_ADC_NR: begin
        sleep_map.mem = 1'b1; // state kept for the converter result
        sleep_map.osc = 1'b1;
        sleep_map.irq = 1'b1;
        sleep_map.async_tmr = 1'b1;
        sleep_map.adc = 1'b1;
      end
      smc_pkg::SMC_MODE_PWR_DOWN: begin
        sleep_map = smc_pkg::SMC_DOM_NONE;
      end
      smc_pkg::SMC_MODE_PWR_SAVE: begin
        sleep_map.async_tmr = 1'b1;
      end
      smc_pkg::SMC_MODE_STANDBY: begin
        sleep_map.osc = 1'b1;
      end
      smc_pkg::SMC_MODE_EXT_STBY: begin
        sleep_map.osc = 1'b1;
        sleep_map.async_tmr = 1'b1;
      end
      default: begin
        sleep_map = smc_pkg::SMC_DOM_ALL;
      end
    endcase
  end

  // ***************************************************************
  // sleep / wake sequencer
  // ***************************************************************
  typedef enum logic [1:0] {
    SMC_ST_RUN,
    SMC_ST_SLEEP,
    SMC_ST_WAKE
  } smc_state_t;

  smc_state_t state_ff;
  smc_state_t nxt_state;
  logic [smc_pkg::SMC_CNT_W-1:0] cnt_ff;
  logic wake_ev;
  logic osc_stopped;

  // power-down, power-save and adc-nr respond only to interrupts; idle
  // also wakes on the same sources since the irq system keeps running
  assign wake_ev = irq_pend_i | ext_irq_s | async_irq_s;

  // the gating in force while asleep tells whether the oscillator stopped;
  // a mode write in the wake cycle must not change the settle length
  assign osc_stopped = !dom_en_o.osc;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SMC_ST_RUN: begin
        if (sleep_req_i && sleep_en_i) begin
          nxt_state = SMC_ST_SLEEP;
        end
      end
      SMC_ST_SLEEP: begin
        if (wake_ev) begin
          nxt_state = SMC_ST_WAKE;
        end
      end
      SMC_ST_WAKE: begin
        if (cnt_ff == smc_pkg::SMC_CNT_ZERO) begin
          nxt_state = SMC_ST_RUN;
        end
      end
      default: begin
        nxt_state = SMC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= SMC_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // settle counter loaded on wake; a running oscillator needs one cycle
  // only, trading start-up time against oscillator standby current
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= smc_pkg::SMC_CNT_ZERO;
    end else if (state_ff == SMC_ST_SLEEP && wake_ev) begin
      if (osc_stopped) begin
        cnt_ff <= smc_pkg::SMC_CNT_W'(WAKE_CYC);
      end else begin
        cnt_ff <= smc_pkg::SMC_CNT_ONE;
      end
    end else if (state_ff == SMC_ST_WAKE &&
                 cnt_ff != smc_pkg::SMC_CNT_ZERO) begin
      cnt_ff <= cnt_ff - smc_pkg::SMC_CNT_ONE;
    end
  end

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  smc_pkg::smc_dom_t nxt_dom;

  // every domain runs except while asleep; clocks return on wake entry
  always_comb begin
    nxt_dom = smc_pkg::SMC_DOM_ALL;
    if (nxt_state == SMC_ST_SLEEP) begin
      nxt_dom = sleep_map;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dom_en_o <= smc_pkg::SMC_DOM_ALL;
      cpu_run_o <= 1'b1;
      asleep_o <= 1'b0;
      mode_o <= smc_pkg::SMC_MODE_IDLE;
      mode_bad_o <= 1'b0;
    end else begin
      dom_en_o <= nxt_dom;
      // core waits until the wake counter has drained
      cpu_run_o <= (nxt_state == SMC_ST_RUN);
      asleep_o <= (nxt_state == SMC_ST_SLEEP);
      mode_o <= nxt_mode;
      mode_bad_o <= mode_wr_i ? !mode_legal : bad_ff;
    end
  end

endmodule // smc_sleep_ctrl
`default_nettype wire

// File: testbench/smc_sleep_monitor.sv
// checker: port assertions for the sleep controller
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_monitor #(
  parameter int WAKE_CYC = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] mode_sel_i,
  input wire logic mode_wr_i,
  input wire logic sleep_en_i,
  input wire logic sleep_req_i,
  input wire logic irq_pend_i,
  input wire logic ext_irq_i,
  input wire logic async_irq_i,
  input wire smc_pkg::smc_dom_t dom_en_o,
  input wire logic cpu_run_o,
  input wire logic asleep_o,
  input wire logic [2:0] mode_o,
  input wire logic mode_bad_o
);
  // ****
  // helpers
  // ****
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] wcnt_ff;
  logic osc_ff;
  logic [2:0] irq_ff;
  logic [7:0] gmap [8] = '{8'h7d, 8'h4f, 8'h00, 8'h04,
                           8'h00, 8'h00, 8'h01, 8'h05};
  // async wake lines reach the core late, so remember a few cycles
  always_ff @(posedge ref_clk_i) begin
    irq_ff <= {irq_ff[1:0], ext_irq_i | async_irq_i};
  end
  // cycles since sleep was left, and whether the oscillator kept running
  always_ff @(posedge ref_clk_i) begin
    if ($fell(asleep_o)) begin
      wcnt_ff <= 16'h0002;
      osc_ff <= $past(dom_en_o.osc);
    end else begin
      wcnt_ff <= wcnt_ff + 16'h0001;
    end
  end
  a_sleep_entry: assert property (
    sleep_req_i && sleep_en_i && !asleep_o && cpu_run_o
    |=> asleep_o && !cpu_run_o) else $error("sleep not entered");
  a_no_sleep: assert property (
    !asleep_o && !(sleep_req_i && sleep_en_i) |=> !asleep_o)
    else $error("sleep without request");
  a_awake_all: assert property (
    !asleep_o |-> dom_en_o == smc_pkg::SMC_DOM_ALL)
    else $error("domain gated while awake");
  a_gate_map: assert property (
    asleep_o |-> dom_en_o == gmap[mode_o]) else $error("wrong gating");
  a_wake_exit: assert property (
    asleep_o && irq_pend_i |=> !asleep_o && !cpu_run_o)
    else $error("no wake on interrupt");
  a_stay_frozen: assert property (
    asleep_o && !irq_pend_i && !(ext_irq_i || async_irq_i)
    && irq_ff == 3'h0 |=> asleep_o) else $error("woke without cause");
  a_wake_delay: assert property (
    $rose(cpu_run_o) && $past(rst_n_i)
    |-> wcnt_ff == (osc_ff ? 16'h0003 : 16'(WAKE_CYC + 2)))
    else $error("core resumed at wrong time");
  a_mode_write: assert property (
    mode_wr_i && mode_sel_i[2:1] != 2'b10
    |=> mode_o == $past(mode_sel_i) && !mode_bad_o)
    else $error("mode not stored");
  a_mode_refuse: assert property (
    mode_wr_i && mode_sel_i[2:1] == 2'b10 |=> $stable(mode_o) && mode_bad_o)
    else $error("reserved mode taken");
endmodule // smc_sleep_monitor
bind smc_sleep_ctrl smc_sleep_monitor #(.WAKE_CYC(WAKE_CYC)) u_mon (
  .ref_clk_i, .rst_n_i, .mode_sel_i, .mode_wr_i, .sleep_en_i, .sleep_req_i,
  .irq_pend_i, .ext_irq_i, .async_irq_i, .dom_en_o, .cpu_run_o, .asleep_o,
  .mode_o, .mode_bad_o);
`default_nettype wire

// File: testbench/smc_sleep_ctrl_tb.sv
// testbench: sleep controller modes, gating and wake timing
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl_tb;
  // ****
  // stimulus and scoreboard
  // ****
  localparam int WC = 2; // short settle keeps the run brief
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] sel = 3'h0, mo, md = 3'h0;
  logic wr = 1'b0, en = 1'b0, req = 1'b0, irq = 1'b0, ext = 1'b0;
  logic asy = 1'b0, cpu, slp, bad, bd = 1'b0;
  smc_pkg::smc_dom_t dom;
  logic [13:0] q[$];
  logic [13:0] e;
  int num_errors = 0, n_tests = 0, cyc = 0;
  logic [7:0] gmap [8] = '{8'h7d, 8'h4f, 8'h00, 8'h04,
                           8'h00, 8'h00, 8'h01, 8'h05};
  smc_sleep_ctrl #(.WAKE_CYC(WC)) uut (.ref_clk_i, .rst_n_i,
    .mode_sel_i(sel), .mode_wr_i(wr), .sleep_en_i(en), .sleep_req_i(req),
    .irq_pend_i(irq), .ext_irq_i(ext), .async_irq_i(asy), .dom_en_o(dom),
    .cpu_run_o(cpu), .asleep_o(slp), .mode_o(mo), .mode_bad_o(bad));
  always #4 ref_clk_i = ~ref_clk_i;
  // note what the outputs must show after the coming edge
  task automatic t(input logic a, input logic c, input logic [7:0] d);
    q.push_back({a, c, d, md, bd});
    @(negedge ref_clk_i);
  endtask
  // wake by one of three sources; async ones arrive a few cycles late
  task automatic wake(input int s, input logic o);
    int n;
    n = o ? 3 : WC + 2;
    if (s == 0) begin
      irq = 1'b1;
      t(1'b0, 1'b0, 8'hff);
      irq = 1'b0;
    end else begin
      {ext, asy} = (s == 1) ? 2'b10 : 2'b01;
      for (int k = 0; k < 8 && slp; k++) @(negedge ref_clk_i);
      {ext, asy} = 2'b00;
    end
    for (int k = 2; k <= n; k++) t(1'b0, k == n, 8'hff);
  endtask
  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watcher: oldest note against settled outputs
  always @(posedge ref_clk_i) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      n_tests++;
      if ({slp, cpu, dom, mo, bad} !== e) begin
        num_errors++;
        $display("unexpected at %0t: got %h want %h", $time,
                 {slp, cpu, dom, mo, bad}, e);
      end
    end
  end
  // a hang counts as a mismatch
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      wrap_up;
    end
  end
  // every code written, each mode slept in and woken from
  initial begin
    void'($urandom(72969));
    repeat (15) @(negedge ref_clk_i);
    t(1'b0, 1'b1, 8'hff);
    rst_n_i = 1'b1;
    for (int m = 0; m < 8; m++) begin
      sel = 3'(m);
      wr = 1'b1;
      bd = sel[2:1] == 2'b10;
      if (!bd) md = sel;
      t(1'b0, 1'b1, 8'hff);
      wr = 1'b0;
      sel = 3'($urandom);
      en = 1'b0;
      req = 1'b1;
      t(1'b0, 1'b1, 8'hff);
      en = 1'b1;
      t(1'b1, 1'b0, gmap[md]);
      req = 1'b0;
      en = 1'($urandom);
      t(1'b1, 1'b0, gmap[md]);
      wake(m % 3, gmap[md][0]);
    end
    // field rewritten while asleep, then a hardware reset ends the sleep
    sel = 3'h2;
    wr = 1'b1;
    md = 3'h2;
    bd = 1'b0;
    t(1'b0, 1'b1, 8'hff);
    wr = 1'b0;
    en = 1'b1;
    req = 1'b1;
    t(1'b1, 1'b0, gmap[md]);
    req = 1'b0;
    sel = 3'h3;
    wr = 1'b1;
    md = 3'h3;
    t(1'b1, 1'b0, gmap[md]);
    wr = 1'b0;
    rst_n_i = 1'b0;
    md = 3'h0;
    t(1'b0, 1'b1, 8'hff);
    rst_n_i = 1'b1;
    t(1'b0, 1'b1, 8'hff);
    wrap_up;
  end
endmodule // smc_sleep_ctrl_tb
`default_nettype wire
